// *** design/uif_regs.svh ***
`ifndef UIF_REGS_SVH
`define UIF_REGS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UIF_STS_OFS 8'h24
`define UIF_IEN_OFS 8'h28
`define UIF_FRM_OFS 8'h2C
`define UIF_PLB_OFS 8'h34
`define UIF_ALP_OFS 8'h38
`define UIF_CFG_OFS 8'h60
`define UIF_P0_OFS 8'h64
`define UIF_P1_OFS 8'h68
// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define UIF_B_TD 0
`define UIF_B_ERR 1
`define UIF_B_PCD 2
`define UIF_B_ROL 3
`define UIF_B_SYS 4
`define UIF_B_AA 5
`define UIF_SRC_N 6
`define UIF_THR_MASK 6'h23
`define UIF_FRM_W 14
`define UIF_PLB_LSB 12
`define UIF_ALP_LSB 5
`define UIF_PO_BIT 13
`define UIF_CF_BIT 0
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define UIF_PORT_RST 32'h0000_2000
`define UIF_ZERO32 32'h0000_0000
`define UIF_OWN_ALL 2'h3
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define UIF_FRAME_NS 125000
`define UIF_CLK_NS 50
`define UIF_THR_FRAMES 8
`endif

// *** design/uif_pkg.sv ***
package uif_pkg;
  typedef logic [5:0] uif_src_t;
  typedef logic [13:0] uif_frame_t;
  typedef logic [1:0] uif_owner_t;
endpackage : uif_pkg

// *** design/uif_top.sv ***
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`include "uif_regs.svh"
module uif_top #(
  parameter int FRAME_CYC = `UIF_FRAME_NS / `UIF_CLK_NS,
  parameter int THRESH_FRAMES = `UIF_THR_FRAMES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic async_advance_evt,
  input wire logic system_error_evt,
  input wire logic port_change_evt,
  input wire logic transfer_error_evt,
  input wire logic transfer_done_evt,
  output logic irq,
  output logic frame_tick,
  output logic [1:0] port_owner
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [15:0] cyc_q;
  logic frame_tick_q;
  logic [7:0] thr_q;
  logic thr_tick;
  uif_pkg::uif_frame_t frame_counter_q;
  uif_pkg::uif_src_t sts_q;
  uif_pkg::uif_src_t sts_d;
  uif_pkg::uif_src_t ien_q;
  uif_pkg::uif_src_t pend_q;
  uif_pkg::uif_src_t set_v;
  uif_pkg::uif_src_t clr_v;
  uif_pkg::uif_src_t cap_v;
  logic [31:`UIF_PLB_LSB] plb_q;
  logic [31:`UIF_ALP_LSB] alp_q;
  logic configured_flag_bit_q;
  logic cf_set;
  uif_pkg::uif_owner_t port_owner_q;
  logic wr_sts;
  logic wr_frm;
  logic wr_cfg;
  logic rollover;

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign frame_tick = frame_tick_q;
  assign port_owner = port_owner_q;

  assign wr_sts = wr_en && (addr == `UIF_STS_OFS);
  assign wr_frm = wr_en && (addr == `UIF_FRM_OFS);
  assign wr_cfg = wr_en && (addr == `UIF_CFG_OFS);

  // ------------------------------------------------------------
  // frame and threshold timing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 16'h0000;
      frame_tick_q <= 1'b0;
    end else if (cyc_q == 16'(FRAME_CYC - 1)) begin
      cyc_q <= 16'h0000;
      frame_tick_q <= 1'b1;
    end else begin
      cyc_q <= cyc_q + 16'h0001;
      frame_tick_q <= 1'b0;
    end
  end

  assign thr_tick = frame_tick_q && (thr_q == 8'(THRESH_FRAMES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= 8'h00;
    end else if (thr_tick) begin
      thr_q <= 8'h00;
    end else if (frame_tick_q) begin
      thr_q <= thr_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // frame counter
  // ------------------------------------------------------------
  assign rollover = frame_tick_q && !wr_frm && (&frame_counter_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_counter_q <= 14'h0000;
    end else if (wr_frm) begin
      frame_counter_q <= wdata[`UIF_FRM_W-1:0];
    end else if (frame_tick_q) begin
      frame_counter_q <= frame_counter_q + 14'h0001;
    end
  end

  // ------------------------------------------------------------
  // status, enable and pending
  // ------------------------------------------------------------
  always_comb begin
    set_v = '0;
    set_v[`UIF_B_TD] = transfer_done_evt;
    set_v[`UIF_B_ERR] = transfer_error_evt;
    set_v[`UIF_B_PCD] = port_change_evt;
    set_v[`UIF_B_ROL] = rollover;
    set_v[`UIF_B_SYS] = system_error_evt;
    set_v[`UIF_B_AA] = async_advance_evt;
    clr_v = wr_sts ? wdata[`UIF_SRC_N-1:0] : '0;
    sts_d = (sts_q & ~clr_v) | set_v;
    cap_v = thr_tick ? (sts_q & ien_q & `UIF_THR_MASK) : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_q <= '0;
    end else begin
      sts_q <= sts_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_q <= '0;
    end else if (wr_en && (addr == `UIF_IEN_OFS)) begin
      ien_q <= wdata[`UIF_SRC_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q | cap_v) & sts_d;
    end
  end

  // immediate sources skip the threshold
  assign irq_d = (|(sts_q & ien_q & ~`UIF_THR_MASK))
               | (|(pend_q & ien_q));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ------------------------------------------------------------
  // list pointers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      plb_q <= '0;
    end else if (wr_en && (addr == `UIF_PLB_OFS)) begin
      plb_q <= wdata[31:`UIF_PLB_LSB];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alp_q <= '0;
    end else if (wr_en && (addr == `UIF_ALP_OFS)) begin
      alp_q <= wdata[31:`UIF_ALP_LSB];
    end
  end

  // ------------------------------------------------------------
  // configured flag and port ownership
  // ------------------------------------------------------------
  assign cf_set = wr_cfg && wdata[`UIF_CF_BIT] && !configured_flag_bit_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configured_flag_bit_q <= 1'b0;
    end else if (wr_cfg) begin
      configured_flag_bit_q <= wdata[`UIF_CF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_owner_q <= `UIF_OWN_ALL;
    end else if (cf_set) begin
      port_owner_q <= '0;
    end else if (!configured_flag_bit_q) begin
      port_owner_q <= `UIF_OWN_ALL;
    end else if (wr_en && (addr == `UIF_P0_OFS)) begin
      port_owner_q[0] <= wdata[`UIF_PO_BIT];
    end else if (wr_en && (addr == `UIF_P1_OFS)) begin
      port_owner_q[1] <= wdata[`UIF_PO_BIT];
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = `UIF_ZERO32;
    if (!rd_en) begin
      rdata_d = `UIF_ZERO32;
    end else if (addr == `UIF_STS_OFS) begin
      rdata_d[`UIF_SRC_N-1:0] = sts_q;
    end else if (addr == `UIF_IEN_OFS) begin
      rdata_d[`UIF_SRC_N-1:0] = ien_q;
    end else if (addr == `UIF_FRM_OFS) begin
      rdata_d[`UIF_FRM_W-1:0] = frame_counter_q;
    end else if (addr == `UIF_PLB_OFS) begin
      rdata_d[31:`UIF_PLB_LSB] = plb_q;
    end else if (addr == `UIF_ALP_OFS) begin
      rdata_d[31:`UIF_ALP_LSB] = alp_q;
    end else if (addr == `UIF_CFG_OFS) begin
      rdata_d[`UIF_CF_BIT] = configured_flag_bit_q;
    end else if (addr == `UIF_P0_OFS) begin
      rdata_d[`UIF_PO_BIT] = port_owner_q[0];
    end else if (addr == `UIF_P1_OFS) begin
      rdata_d[`UIF_PO_BIT] = port_owner_q[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `UIF_ZERO32;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_aa_threshold: assert property (
    thr_tick && sts_q[`UIF_B_AA] && ien_q[`UIF_B_AA] && !clr_v[`UIF_B_AA]
    |=> pend_q[`UIF_B_AA] ##1 irq_q)
    else $error("async advance not raised at threshold");

  a_sts_sticky: assert property (
    sts_q[`UIF_B_TD] && !clr_v[`UIF_B_TD] |=> sts_q[`UIF_B_TD])
    else $error("status flag lost without clear");

  a_sys_error_fast: assert property (
    sts_q[`UIF_B_SYS] && ien_q[`UIF_B_SYS] |=> irq_q)
    else $error("system error interrupt delayed");

  a_roll_irq: assert property (
    sts_q[`UIF_B_ROL] && ien_q[`UIF_B_ROL] |=> irq_q)
    else $error("rollover interrupt missing");

  a_port_change_irq: assert property (
    sts_q[`UIF_B_PCD] && ien_q[`UIF_B_PCD] |=> irq_q)
    else $error("port change interrupt missing");

  a_err_threshold: assert property (
    thr_tick && sts_q[`UIF_B_ERR] && ien_q[`UIF_B_ERR]
    && !clr_v[`UIF_B_ERR] |=> ##1 irq_q)
    else $error("transfer error not raised at threshold");

  a_done_threshold: assert property (
    thr_tick && sts_q[`UIF_B_TD] && ien_q[`UIF_B_TD]
    && !clr_v[`UIF_B_TD] |=> ##1 irq_q)
    else $error("transfer done not raised at threshold");

  a_rsvd_zero: assert property (
    rd_en && (addr == `UIF_IEN_OFS || addr == `UIF_FRM_OFS)
    |=> rdata_q[31:16] == 16'h0000)
    else $error("reserved bits not zero");

  a_frame_inc: assert property (
    frame_tick_q && !wr_frm
    |=> frame_counter_q == 14'($past(frame_counter_q) + 14'h0001))
    else $error("frame counter did not advance");

  a_list_align: assert property (
    rd_en && (addr == `UIF_PLB_OFS || addr == `UIF_ALP_OFS)
    |=> rdata_q[4:0] == 5'h00)
    else $error("list pointer low bits not zero");

  a_cf_route: assert property (
    cf_set |=> port_owner_q == 2'h0 && configured_flag_bit_q)
    else $error("ports not routed on configure");

  a_roll_flag: assert property (
    rollover |=> sts_q[`UIF_B_ROL] && frame_counter_q == 14'h0000)
    else $error("rollover flag not set on wrap");

  a_thr_gate: assert property (
    ((ien_q & ~`UIF_THR_MASK) == '0) && pend_q == '0 |=> !irq_q)
    else $error("interrupt without enabled source");

  a_sts_w1c: assert property (
    wr_sts && wdata[`UIF_B_PCD] && !set_v[`UIF_B_PCD]
    |=> !sts_q[`UIF_B_PCD])
    else $error("status flag not cleared by write");

  a_set_wins: assert property (
    set_v != '0
    |=> (sts_q & $past(set_v)) == $past(set_v))
    else $error("status event lost to a clear");

  a_pend_subset: assert property (
    (pend_q & ~sts_q) == '0)
    else $error("pending bit without status bit");

  a_pend_at_tick: assert property (
    !thr_tick && pend_q == '0
    |=> pend_q == '0)
    else $error("pending captured off a threshold tick");

  a_frame_write: assert property (
    wr_frm
    |=> frame_counter_q == uif_pkg::uif_frame_t'($past(wdata)))
    else $error("frame counter write lost");

  a_tick_single: assert property (
    frame_tick_q
    |=> !frame_tick_q)
    else $error("frame tick longer than one cycle");

  a_rdata_idle: assert property (
    !rd_en
    |=> rdata_q == `UIF_ZERO32)
    else $error("read data not zero without read");

  a_plb_align: assert property (
    rd_en && addr == `UIF_PLB_OFS
    |=> rdata_q[`UIF_PLB_LSB-1:0] == '0)
    else $error("periodic base low bits not zero");

  a_cfg_rsvd: assert property (
    rd_en && addr == `UIF_CFG_OFS
    |=> rdata_q[31:`UIF_CF_BIT+1] == '0)
    else $error("configured flag reserved bits not zero");

  a_owner_forced: assert property (
    !configured_flag_bit_q && !cf_set
    |=> port_owner_q == `UIF_OWN_ALL)
    else $error("port owner not forced while unconfigured");

  // ------------------------------------------------------------
  // cover properties
  // ------------------------------------------------------------
  c_irq_rise: cover property ($rose(irq_q));
  c_rollover: cover property (rollover ##1 irq_q);
  c_cf_set: cover property (cf_set);
  c_threshold: cover property (thr_tick && pend_q == '0 ##1 pend_q != '0);
  c_owner_write: cover property (
    configured_flag_bit_q && wr_en && addr == `UIF_P0_OFS);
endmodule : uif_top

// *** tb/uif_host_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// host software register access
// ----------------------------------------
module uif_host_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // one-cycle write; status flags cleared by writing ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rd
endmodule : uif_host_model

// *** tb/usb2_host_interrupt_frame_regs_test.sv ***
`timescale 1ns/10ps
`include "uif_regs.svh"
module usb2_host_interrupt_frame_regs_test;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } uif_row_t;
  localparam uif_row_t ROWS [6] = '{
    '{`UIF_IEN_OFS, 32'hFFFF_FFFF, 32'h0000_003F},
    '{`UIF_PLB_OFS, 32'hFFFF_FFFF, 32'hFFFF_F000},
    '{`UIF_ALP_OFS, 32'hFFFF_FFFF, 32'hFFFF_FFE0},
    '{8'h44, 32'hFFFF_FFFF, 32'h0000_0000},
    '{`UIF_P0_OFS, 32'hFFFF_FFFF, 32'h0000_2000},
    '{`UIF_IEN_OFS, 32'h0000_0000, 32'h0000_0000}};
  int imm [2] = '{4, 2};
  int thr [3] = '{5, 1, 0};
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic clk, rst_n, wr_en, rd_en, irq, frame_tick;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [5:0] ev;
  logic [1:0] port_owner;
  uif_host_model host (.clk(clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
  uif_top #(.FRAME_CYC(20), .THRESH_FRAMES(2)) dut (.clk(clk),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .async_advance_evt(ev[5]),
    .system_error_evt(ev[4]), .port_change_evt(ev[2]),
    .transfer_error_evt(ev[1]), .transfer_done_evt(ev[0]), .irq(irq),
    .frame_tick(frame_tick), .port_owner(port_owner));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // waits for frame_tick (sel 0) or irq (sel 1), bounded
  task automatic wait_hi(input int sel);
    int k;
    for (k = 0; k < 60; k++) begin
      @(negedge clk);
      if (((sel == 0) ? frame_tick : irq) === 1'b1) break;
    end
    if (k == 60) begin
      mismatches++;
      results();
    end
    @(posedge clk);
  endtask : wait_hi
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask : pulse
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    ev = 6'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("owner rst", 32'h3, {30'h0, port_owner});
    @(posedge clk);
    host.rd(`UIF_FRM_OFS, v);
    chk("frame rst", 32'h0, v);
    host.rd(`UIF_P1_OFS, v);
    chk("port1 rst", 32'h0000_2000, v);
    foreach (ROWS[i]) begin
      host.wr(ROWS[i].a, ROWS[i].d);
      host.rd(ROWS[i].a, v);
      chk("table", ROWS[i].e, v);
    end
    host.wr(`UIF_IEN_OFS, 32'h8);
    wait_hi(0);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (frame_tick !== 1'b1 && cyc < 60);
    chk("period", 32'h14, cyc);
    @(posedge clk);
    host.wr(`UIF_FRM_OFS, 32'hFFFF_FFFE);
    wait_hi(0);
    host.rd(`UIF_FRM_OFS, v);
    chk("count", 32'h0000_3FFF, v);
    wait_hi(0);
    host.rd(`UIF_FRM_OFS, v);
    chk("wrap", 32'h0, v);
    host.rd(`UIF_STS_OFS, v);
    chk("rollover", 32'h8, v);
    chk("roll irq", 32'h1, {31'h0, irq});
    host.wr(`UIF_STS_OFS, 32'h8);
    @(negedge clk);
    chk("roll clr", 32'h0, {31'h0, irq});
    @(posedge clk);
    foreach (imm[i]) begin
      host.wr(`UIF_IEN_OFS, 32'h1 << imm[i]);
      pulse(imm[i]);
      @(negedge clk);
      chk("imm early", 32'h0, {31'h0, irq});
      @(negedge clk);
      chk("imm irq", 32'h1, {31'h0, irq});
      @(posedge clk);
      host.wr(`UIF_STS_OFS, 32'h1 << imm[i]);
      @(negedge clk);
      chk("imm clr", 32'h0, {31'h0, irq});
      @(posedge clk);
    end
    foreach (thr[i]) begin
      host.wr(`UIF_IEN_OFS, 32'h1 << thr[i]);
      wait_hi(0);
      pulse(thr[i]);
      repeat (3) @(negedge clk);
      chk("thr early", 32'h0, {31'h0, irq});
      wait_hi(1);
      host.wr(`UIF_STS_OFS, 32'h1 << thr[i]);
      @(negedge clk);
      chk("thr clr", 32'h0, {31'h0, irq});
      @(posedge clk);
    end
    host.wr(`UIF_IEN_OFS, 32'h0);
    pulse(2);
    repeat (3) @(negedge clk);
    chk("masked", 32'h0, {31'h0, irq});
    @(posedge clk);
    host.rd(`UIF_STS_OFS, v);
    chk("pcd sts", 32'h4, v);
    host.wr(`UIF_STS_OFS, 32'h4);
    host.rd(`UIF_CFG_OFS, v);
    chk("cfg rst", 32'h0, v);
    host.wr(`UIF_CFG_OFS, 32'hFFFF_FFFF);
    @(negedge clk);
    chk("owner cfg", 32'h0, {30'h0, port_owner});
    @(posedge clk);
    host.rd(`UIF_CFG_OFS, v);
    chk("cfg", 32'h1, v);
    host.rd(`UIF_P1_OFS, v);
    chk("port1 cfg", 32'h0, v);
    host.wr(`UIF_P0_OFS, 32'h0000_2000);
    host.rd(`UIF_P0_OFS, v);
    chk("port0 own", 32'h0000_2000, v);
    chk("owner out", 32'h1, {30'h0, port_owner});
    results();
  end
endmodule : usb2_host_interrupt_frame_regs_test
